// ==== src/vector_io_pkg.sv ====
package vector_io_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CONTROL      = 8'h00;
	localparam logic [7:0] OFF_INPUT_CONFIG = 8'h04;
	localparam logic [7:0] OFF_TRANS_LOW    = 8'h08;
	localparam logic [7:0] OFF_TRANS_HIGH   = 8'h0c;
	localparam logic [7:0] OFF_ALPHA_REF    = 8'h10;
	localparam logic [7:0] OFF_STATUS       = 8'h14;
	// Control register fields
	localparam int SRC_LSB     = 13;
	localparam int REORDER_BIT = 8;
	localparam int SIZE_LSB    = 16;
	localparam int DE_BIT      = 24;
	localparam int DB_BIT      = 25;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_e4e4;
	localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
	// Instruction field position
	localparam int OP_LSB = 57;
	localparam int OP_MSB = 58;
	typedef enum logic [1:0] {
		OP_NOOP     = 2'h0,
		OP_FEEDBACK = 2'h1,
		OP_INPUT    = 2'h2,
		OP_OUTPUT   = 2'h3
	} op_type;
	// Bus codes
	typedef enum logic [2:0] {
		BUS_A = 3'h0, BUS_B = 3'h1, BUS_Q = 3'h2, BUS_F = 3'h3,
		BUS_M = 3'h4, BUS_U = 3'h5, BUS_D = 3'h6, BUS_V = 3'h7
	} bus_type;
	// Diffusion size codes, byte reorder off value, vector length and alpha limits
	localparam logic [1:0] no_diffusion_code         = 2'h0;
	localparam logic [1:0] six_bit_diffusion_code    = 2'h1;
	localparam logic [1:0] five_bit_diffusion_code   = 2'h2;
	localparam logic [1:0] four_bit_diffusion_code   = 2'h3;
	localparam logic [0:0] byte_reorder_off          = 1'h0;
	localparam logic [8:0] MAX_VECTOR                = 9'h080;
	localparam logic [7:0] FULL_ALPHA                = 8'hff;
endpackage

// ==== src/vector_io_output_path.sv ====
`timescale 1ns/100ps
module vector_io_output_path (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic        i_reg_write,
	input  wire logic        i_reg_read,
	output logic      [31:0] o_reg_rdata,
	input  wire logic        i_instr_valid,
	input  wire logic [63:0] i_instruction,
	input  wire logic        i_vector_access,
	input  wire logic [7:0]  i_vector_length,
	input  wire logic        i_scalar_access,
	input  wire logic [31:0] i_a_bus,
	input  wire logic [31:0] i_b_bus,
	input  wire logic [31:0] i_q_bus,
	input  wire logic [31:0] i_f_bus,
	input  wire logic [31:0] i_m_bus,
	input  wire logic [31:0] i_u_bus,
	input  wire logic [31:0] i_d_bus,
	input  wire logic [15:0] i_in_pixel,
	output logic      [31:0] o_v_bus,
	output logic      [31:0] o_out_data,
	output logic             o_out_valid,
	output logic             o_out_write_enable,
	output logic             o_op_ready
);
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_VECTOR = 3'b010,
		ST_SCALAR = 3'b100
	} access_state_type;

	access_state_type       state;
	logic [8:0]             remaining;
	logic [31:0]            output_path_control;
	logic                   input_wide;
	logic [23:0]            trans_low;
	logic [23:0]            trans_high;
	logic [7:0]             alpha_ref;
	logic [1:0]             op;
	logic                   exec;
	logic                   out_fire;
	logic                   in_fire;
	logic                   fb_fire;
	logic [31:0]            selected_word;
	logic [31:0]            reordered_word;
	logic [31:0]            diffused_word;
	logic [31:0]            in_word;
	logic [31:0]            in_reordered;
	logic                   in_transparent;
	logic                   diffuse_enable_flag;
	logic                   diffusion_begin_flag;
	logic                   begin_set;
	logic                   alpha_pass;

	// Pick one source byte per output lane
	function automatic logic [31:0] byte_pick(input logic [31:0] w,
		input logic [7:0] sel);
		logic [31:0] r;
		r = vector_io_pkg::ZERO_WORD;
		for (int l = 0; l < 4; l++) begin
			r[8*l +: 8] = w[8*sel[2*l +: 2] +: 8];
		end
		return r;
	endfunction

	// Mask of remainder bits carried for a size code
	function automatic logic [7:0] carry_mask(input logic [1:0] code);
		logic [7:0] m;
		unique case (code)
			vector_io_pkg::six_bit_diffusion_code:  m = 8'h03;
			vector_io_pkg::five_bit_diffusion_code: m = 8'h07;
			vector_io_pkg::four_bit_diffusion_code: m = 8'h0f;
			default:                                m = 8'h00;
		endcase
		return m;
	endfunction

	// Field decode and operation permission
	assign op = i_instruction[vector_io_pkg::OP_MSB:vector_io_pkg::OP_LSB];
	assign o_op_ready = (state != ST_IDLE);
	assign exec = i_instr_valid && o_op_ready
		&& (op != vector_io_pkg::OP_NOOP);
	assign out_fire = exec && (op == vector_io_pkg::OP_OUTPUT);
	assign in_fire  = exec && (op == vector_io_pkg::OP_INPUT);
	assign fb_fire  = exec && (op == vector_io_pkg::OP_FEEDBACK);
	assign diffuse_enable_flag  = output_path_control[vector_io_pkg::DE_BIT];
	assign diffusion_begin_flag = output_path_control[vector_io_pkg::DB_BIT];
	assign begin_set = out_fire && diffuse_enable_flag
		&& !diffusion_begin_flag;

	// Access window granted by the partner's access functions
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			remaining <= 9'h000;
		end else if (i_vector_access) begin
			state <= ST_VECTOR;
			remaining <= (i_vector_length == 8'h00
				|| {1'b0, i_vector_length} > vector_io_pkg::MAX_VECTOR)
				? vector_io_pkg::MAX_VECTOR
				: {1'b0, i_vector_length};
		end else if (i_scalar_access) begin
			state <= ST_SCALAR;
			remaining <= 9'h001;
		end else if (exec) begin
			unique case (state)
				ST_VECTOR: begin
					remaining <= remaining - 9'h001;
					if (remaining == 9'h001) begin
						state <= ST_IDLE;
					end
				end
				ST_SCALAR: begin
					remaining <= 9'h000;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Control register, hardware set of begin flag wins over write
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			output_path_control <= vector_io_pkg::CONTROL_RESET;
		end else if (i_reg_write
			&& i_reg_addr == vector_io_pkg::OFF_CONTROL) begin
			output_path_control <= i_reg_wdata;
			if (begin_set) begin
				output_path_control[vector_io_pkg::DB_BIT] <= 1'b1;
			end
		end else if (begin_set) begin
			output_path_control[vector_io_pkg::DB_BIT] <= 1'b1;
		end
	end

	// Input and alpha test settings
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			input_wide <= 1'b0;
			trans_low  <= 24'h000000;
			trans_high <= 24'h000000;
			alpha_ref  <= 8'h00;
		end else if (i_reg_write) begin
			unique case (i_reg_addr)
				vector_io_pkg::OFF_INPUT_CONFIG: input_wide <= i_reg_wdata[0];
				vector_io_pkg::OFF_TRANS_LOW:  trans_low  <= i_reg_wdata[23:0];
				vector_io_pkg::OFF_TRANS_HIGH: trans_high <= i_reg_wdata[23:0];
				vector_io_pkg::OFF_ALPHA_REF:  alpha_ref  <= i_reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	// Read data stands in the cycle after the read strobe
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= vector_io_pkg::ZERO_WORD;
		end else if (i_reg_read) begin
			unique case (i_reg_addr)
				vector_io_pkg::OFF_CONTROL: o_reg_rdata <= output_path_control;
				vector_io_pkg::OFF_INPUT_CONFIG:
					o_reg_rdata <= {31'h0, input_wide};
				vector_io_pkg::OFF_TRANS_LOW:  o_reg_rdata <= {8'h00, trans_low};
				vector_io_pkg::OFF_TRANS_HIGH: o_reg_rdata <= {8'h00, trans_high};
				vector_io_pkg::OFF_ALPHA_REF:  o_reg_rdata <= {24'h0, alpha_ref};
				vector_io_pkg::OFF_STATUS:
					o_reg_rdata <= {20'h0, state, remaining};
				default: o_reg_rdata <= vector_io_pkg::ZERO_WORD;
			endcase
		end else begin
			o_reg_rdata <= vector_io_pkg::ZERO_WORD;
		end
	end

	// Output bus selection
	always_comb begin
		unique case (output_path_control[vector_io_pkg::SRC_LSB +: 3])
			vector_io_pkg::BUS_A: selected_word = i_a_bus;
			vector_io_pkg::BUS_B: selected_word = i_b_bus;
			vector_io_pkg::BUS_Q: selected_word = i_q_bus;
			vector_io_pkg::BUS_F: selected_word = i_f_bus;
			vector_io_pkg::BUS_M: selected_word = i_m_bus;
			vector_io_pkg::BUS_U: selected_word = i_u_bus;
			vector_io_pkg::BUS_D: selected_word = i_d_bus;
			default:              selected_word = o_v_bus;
		endcase
	end

	// Byte selection follows bus selection
	assign reordered_word =
		(output_path_control[vector_io_pkg::REORDER_BIT]
			== vector_io_pkg::byte_reorder_off)
		? selected_word
		: byte_pick(selected_word, output_path_control[7:0]);

	// Per-lane error diffusion after byte selection
	for (genvar l = 0; l < 4; l++) begin : g_lane
		logic [7:0] prev;
		logic [7:0] carry;
		logic [8:0] sum;
		logic [1:0] size;
		logic       active;
		assign size  = output_path_control[
			vector_io_pkg::SIZE_LSB + 2*l +: 2];
		assign carry = prev & carry_mask(size);
		assign sum   = {1'b0, reordered_word[8*l +: 8]} + {1'b0, carry};
		assign active = diffuse_enable_flag && diffusion_begin_flag;
		assign diffused_word[8*l +: 8] = !active ? reordered_word[8*l +: 8]
			: (sum[8] ? 8'hff : sum[7:0]);
		always_ff @(posedge i_clock or negedge i_rst_n) begin
			if (!i_rst_n) begin
				prev <= 8'h00;
			end else if (out_fire) begin
				prev <= diffused_word[8*l +: 8];
			end
		end
	end

	assign alpha_pass = diffused_word[31:24] >= alpha_ref;

	// Output stream register
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_out_data <= vector_io_pkg::ZERO_WORD;
			o_out_valid <= 1'b0;
			o_out_write_enable <= 1'b0;
		end else begin
			o_out_valid <= out_fire;
			if (out_fire) begin
				o_out_data <= diffused_word;
				o_out_write_enable <= alpha_pass;
			end else begin
				o_out_write_enable <= 1'b0;
			end
		end
	end

	// Input conversion to 32-bit alpha-RGB
	always_comb begin
		if (input_wide) begin
			in_word[23:0] = {i_in_pixel[15:11], i_in_pixel[15:13],
				i_in_pixel[10:5], i_in_pixel[10:9],
				i_in_pixel[4:0], i_in_pixel[4:2]};
		end else begin
			in_word[23:0] = {i_in_pixel[7:5], i_in_pixel[7:5], i_in_pixel[7:6],
				i_in_pixel[4:2], i_in_pixel[4:2], i_in_pixel[4:3],
				{4{i_in_pixel[1:0]}}};
		end
		in_transparent = 1'b1;
		for (int c = 0; c < 3; c++) begin
			if (in_word[8*c +: 8] < trans_low[8*c +: 8]
				|| in_word[8*c +: 8] > trans_high[8*c +: 8]) begin
				in_transparent = 1'b0;
			end
		end
		in_word[31:24] = in_transparent ? 8'h00
			: vector_io_pkg::FULL_ALPHA;
	end

	assign in_reordered =
		(output_path_control[vector_io_pkg::REORDER_BIT]
			== vector_io_pkg::byte_reorder_off)
		? in_word : byte_pick(in_word, output_path_control[7:0]);

	// V bus register, fed by input or feedback
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_v_bus <= vector_io_pkg::ZERO_WORD;
		end else if (in_fire) begin
			o_v_bus <= in_reordered;
		end else if (fb_fire) begin
			o_v_bus <= o_out_data;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	sequence vector_start;
		i_vector_access && i_vector_length == 8'h05;
	endsequence

	noop_hold_a: assert property (
		(state == ST_VECTOR && i_instr_valid && op == 2'h0
			&& !i_vector_access && !i_scalar_access)
		|=> remaining == $past(remaining))
		else $error("noop changed count");
	vector_count_a: assert property (
		vector_start |=> state == ST_VECTOR && remaining == 9'h005)
		else $error("vector count wrong");
	vector_max_a: assert property (
		i_vector_access && i_vector_length == 8'h00 |=> remaining == 9'h080)
		else $error("vector length not 128");
	scalar_once_a: assert property (
		(state == ST_SCALAR && exec && !i_vector_access && !i_scalar_access)
		|=> state == ST_IDLE ##1 !exec)
		else $error("scalar ran twice");
	source_plain_a: assert property (
		(out_fire && !output_path_control[8] && !output_path_control[24]
			&& output_path_control[15:13] == 3'h1)
		|=> o_out_valid && o_out_data == $past(i_b_bus))
		else $error("source select wrong");
	byte_pick_a: assert property (
		(out_fire && output_path_control[8] && !output_path_control[24]
			&& output_path_control[1:0] == 2'h3)
		|=> o_out_data[7:0] == $past(selected_word[31:24]))
		else $error("byte selector wrong");
	begin_flag_a: assert property (
		begin_set |=> diffusion_begin_flag
			&& o_out_data == $past(reordered_word))
		else $error("begin flag not set");
	transparent_a: assert property (
		(in_fire && in_transparent && !output_path_control[8])
		|=> o_v_bus[31:24] == 8'h00)
		else $error("transparent alpha not zero");
	write_enable_a: assert property (
		out_fire |=> o_out_write_enable == $past(alpha_pass))
		else $error("write enable mismatch");
endmodule

// ==== dv/vio_partner.sv ====
`timescale 1ns/100ps
module vio_partner (
	input  wire logic        i_clock,
	output logic             o_instr_valid,
	output logic      [63:0] o_instruction,
	output logic             o_vector_access,
	output logic      [7:0]  o_vector_length,
	output logic             o_scalar_access,
	output logic      [31:0] o_bus [0:6]
);
	// Processor side is idle until the bench asks for work
	initial begin
		o_instr_valid = 1'b0;
		o_instruction = 64'h0;
		o_vector_access = 1'b0;
		o_vector_length = 8'h00;
		o_scalar_access = 1'b0;
		foreach (o_bus[k]) o_bus[k] = 32'h0;
	end
	// Opens a vector or scalar window with a one-cycle access strobe
	task automatic open_window(input logic vec, input logic [7:0] len);
		@(posedge i_clock);
		o_vector_access <= vec;
		o_scalar_access <= ~vec;
		o_vector_length <= len;
		@(posedge i_clock);
		o_vector_access <= 1'b0;
		o_scalar_access <= 1'b0;
	endtask
	// One op per call; chained calls give back-to-back ops
	task automatic op_one(input logic [1:0] op, input int idx,
		input logic [31:0] w);
		logic [63:0] r;
		r = {$urandom, $urandom};
		r[58:57] = op;
		o_instruction <= r;
		o_instr_valid <= 1'b1;
		if (idx < 7) o_bus[idx] <= w;
		@(posedge i_clock);
	endtask
	task automatic op_end();
		o_instr_valid <= 1'b0;
		@(posedge i_clock);
	endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
module testbench;
	logic        i_clock = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata, v_bus, out_data, ctrl, prev, e, vmod;
	logic        out_valid, out_we, op_ready, iv, va, sa;
	logic [63:0] instr;
	logic [7:0]  vlen, aref;
	logic [23:0] lo, hi;
	logic [15:0] pixel = 16'h0;
	logic [31:0] bus [0:6];
	logic [32:0] got [$];
	logic [32:0] exp_q [$];
	int          mismatches = 0;
	int          num_checks = 0;
	always #25 i_clock = ~i_clock;
	vio_partner seq (.i_clock(i_clock), .o_instr_valid(iv),
		.o_instruction(instr), .o_vector_access(va),
		.o_vector_length(vlen), .o_scalar_access(sa), .o_bus(bus));
	vector_io_output_path uut (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd),
		.o_reg_rdata(rdata), .i_instr_valid(iv), .i_instruction(instr),
		.i_vector_access(va), .i_vector_length(vlen),
		.i_scalar_access(sa), .i_a_bus(bus[0]), .i_b_bus(bus[1]),
		.i_q_bus(bus[2]), .i_f_bus(bus[3]), .i_m_bus(bus[4]),
		.i_u_bus(bus[5]), .i_d_bus(bus[6]), .i_in_pixel(pixel),
		.o_v_bus(v_bus), .o_out_data(out_data), .o_out_valid(out_valid),
		.o_out_write_enable(out_we), .o_op_ready(op_ready));
	// Collect every output word with its write enable
	always @(posedge i_clock)
		if (out_valid === 1'b1) got.push_back({out_we, out_data});
	// Byte select, then per-lane diffusion with saturation
	function automatic logic [31:0] shape(input logic [31:0] w,
		input logic [31:0] c, input logic [31:0] p, input logic dif);
		logic [31:0] s;
		logic [8:0]  t;
		logic [7:0]  m;
		for (int k = 0; k < 4; k++) begin
			s[8*k+:8] = c[8] ? w[8*c[2*k+:2]+:8] : w[8*k+:8];
			m = (c[16+2*k+:2] == 2'h0) ? 8'h00 :
				8'((9'h002 << c[16+2*k+:2]) - 9'h001);
			t = {1'b0, s[8*k+:8]} + {1'b0, p[8*k+:8] & m};
			if (dif) s[8*k+:8] = t[8] ? 8'hff : t[7:0];
		end
		return s;
	endfunction
	// Expand 565 or 332 by repeating top bits; alpha zero inside range
	function automatic logic [31:0] argb(input logic [15:0] p,
		input logic wide, input logic [23:0] l, input logic [23:0] h);
		logic [31:0] a;
		a[23:16] = wide ? {p[15:11], p[15:13]} : {p[7:5], p[7:5], p[7:6]};
		a[15:8]  = wide ? {p[10:5], p[10:9]} : {p[4:2], p[4:2], p[4:3]};
		a[7:0]   = wide ? {p[4:0], p[4:2]} : {4{p[1:0]}};
		a[31:24] = 8'h00;
		for (int c = 0; c < 3; c++) begin
			if (a[8*c+:8] < l[8*c+:8] || a[8*c+:8] > h[8*c+:8]) begin
				a[31:24] = 8'hff;
			end
		end
		return a;
	endfunction
	task automatic cmp(input string n, input logic [32:0] x,
		input logic [32:0] g);
		num_checks++;
		if (g !== x) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, x, g);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clock);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Output op with its expected word and alpha test result
	task automatic out_op(input int idx, input logic [31:0] w);
		if (idx == 7) w = vmod;
		e = shape(w, ctrl, prev, ctrl[24] & ctrl[25]);
		prev = e;
		if (ctrl[24]) ctrl[25] = 1'b1;
		exp_q.push_back({e[31:24] >= aref, e});
		seq.op_one(2'h3, idx, w);
	endtask
	task automatic flush(input string n);
		repeat (3) @(posedge i_clock);
		cmp("output count", 33'(exp_q.size()), 33'(got.size()));
		while (exp_q.size() > 0 && got.size() > 0)
			cmp("output word", exp_q.pop_front(), got.pop_front());
		exp_q.delete();
		got.delete();
		$display("test %s done", n);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge i_clock);
		mismatches++;
		stop_test();
	end
	initial begin
		logic [31:0] d;
		void'($urandom(89227));
		prev = 32'h0;
		vmod = 32'h0;
		repeat (20) @(posedge i_clock);
		i_rst_n <= 1'b1;
		reg_rd(vector_io_pkg::OFF_CONTROL, d);
		cmp("control reset", {1'b0, vector_io_pkg::CONTROL_RESET}, {1'b0, d});
		reg_rd(8'h18, d);
		cmp("unmapped read", 33'h0, {1'b0, d});
		aref = 8'($urandom);
		reg_wr(vector_io_pkg::OFF_ALPHA_REF, {24'h0, aref});
		// Every bus code, byte reorder off
		for (int k = 0; k < 8; k++) begin
			ctrl = {16'h0, 3'(k), 4'h0, 1'b0, 8'($urandom)};
			reg_wr(vector_io_pkg::OFF_CONTROL, ctrl);
			seq.open_window(1'b1, 8'h01);
			out_op(k, $urandom);
			seq.op_end();
		end
		flush("bus select");
		// Random byte selectors, including all lanes from byte zero
		for (int k = 0; k < 6; k++) begin
			ctrl = {16'h0, 3'($urandom_range(6)), 4'h0, 1'b1, 8'($urandom)};
			if (k == 0) ctrl[7:0] = 8'h00;
			reg_wr(vector_io_pkg::OFF_CONTROL, ctrl);
			seq.open_window(1'b1, 8'h04);
			repeat (4) out_op(ctrl[15:13], $urandom);
			seq.op_end();
		end
		flush("byte select");
		// Diffusion runs, first with every size code, saturating bytes
		for (int k = 0; k < 3; k++) begin
			ctrl = {6'h0, 2'b01, (k == 0) ? 8'he4 : 8'($urandom), 3'h0,
				4'h0, 1'($urandom), 8'($urandom)};
			reg_wr(vector_io_pkg::OFF_CONTROL, ctrl);
			seq.open_window(1'b1, 8'h0a);
			repeat (10) out_op(0,
				$urandom_range(1) ? 32'hffff_ffff : $urandom);
			seq.op_end();
			reg_rd(vector_io_pkg::OFF_CONTROL, d);
			cmp("begin flag", {1'b0, ctrl}, {1'b0, d});
		end
		flush("diffusion");
		// Scalar window takes one op; noops do not use up a window
		ctrl = vector_io_pkg::CONTROL_RESET;
		// Reset source code selects V; these ops drive bus A
		ctrl[15:13] = 3'h0;
		reg_wr(vector_io_pkg::OFF_CONTROL, ctrl);
		seq.open_window(1'b0, 8'h05);
		out_op(0, $urandom);
		seq.op_one(2'h3, 0, $urandom);
		seq.op_end();
		seq.open_window(1'b1, 8'h02);
		seq.op_one(2'h0, 0, 32'h0);
		out_op(0, $urandom);
		seq.op_one(2'h0, 0, 32'h0);
		out_op(0, $urandom);
		seq.op_one(2'h3, 0, $urandom);
		seq.op_end();
		flush("windows");
		// Zero length means the full 128 ops
		seq.open_window(1'b1, 8'h00);
		repeat (128) out_op(0, $urandom);
		seq.op_one(2'h3, 0, $urandom);
		seq.op_end();
		cmp("window closed", 33'h0, {32'h0, op_ready});
		reg_rd(vector_io_pkg::OFF_STATUS, d);
		cmp("status idle", {1'b0, 20'h0, 3'h1, 9'h0}, {1'b0, d});
		flush("long vector");
		// Feedback loads V, then V is the output source
		seq.open_window(1'b1, 8'h05);
		out_op(0, $urandom);
		seq.op_one(2'h1, 0, 32'h0);
		seq.op_end();
		vmod = e;
		cmp("feedback v bus", {1'b0, vmod}, {1'b0, v_bus});
		ctrl[15:13] = 3'h7;
		reg_wr(vector_io_pkg::OFF_CONTROL, ctrl);
		seq.open_window(1'b1, 8'h01);
		out_op(7, 32'h0);
		seq.op_end();
		flush("feedback");
		// Input conversion, transparent range, input byte select
		for (int k = 0; k < 6; k++) begin
			lo = (k < 2) ? 24'h00_0000 : 24'($urandom);
			hi = (k < 2) ? 24'hff_ffff : 24'($urandom);
			ctrl[8] = (k > 3);
			ctrl[7:0] = (k > 3) ? 8'($urandom) : 8'he4;
			reg_wr(vector_io_pkg::OFF_CONTROL, ctrl);
			reg_wr(vector_io_pkg::OFF_INPUT_CONFIG, {31'h0, 1'(k)});
			reg_wr(vector_io_pkg::OFF_TRANS_LOW, {8'h00, lo});
			reg_wr(vector_io_pkg::OFF_TRANS_HIGH, {8'h00, hi});
			reg_rd(vector_io_pkg::OFF_TRANS_HIGH, d);
			cmp("transparent high", {9'h0, hi}, {1'b0, d});
			seq.open_window(1'b1, 8'h01);
			pixel <= 16'($urandom);
			seq.op_one(2'h2, 7, 32'h0);
			seq.op_end();
			e = shape(argb(pixel, 1'(k), lo, hi), ctrl, 32'h0, 1'b0);
			cmp("input v bus", {1'b0, e}, {1'b0, v_bus});
		end
		$display("test input done");
		stop_test();
	end
endmodule
